// ===== rmlw_reset_mode_lowpower_watchdog.v
// Reset merge, mode capture, low-power control and watchdog timer.
// Assumes the core decodes STOP and WAIT and owns the interrupt mask bit;
// pins arrive asynchronously and pass a three-stage synchroniser.
// Notes on behaviour
// [RULE1] Mode comes from interrupt and mode-select pins at reset pin rise.
// [RULE2] Bootloader needs programming voltage and supply level; else user.
// [RULE3] Latch mode-select at reset rise; watchdog reset reuses the latch.
// [RULE4] Stop with stop-to-halt clear kills oscillator and all processing.
// [RULE5] Either low-power instruction clears the interrupt mask bit.
// [RULE6] Stop exits on interrupt or reset after 4064 cycle delay.
// [RULE7] Stop with stop-to-halt set halts core, timers keep running.
// [RULE8] Halt exits on timer, external interrupt or reset; 1 to 4064 cycles.
// [RULE9] Wait halts core; timers run; exits on timer, interrupt or reset.
// [RULE10] Low-power modes keep registers, memory and lines unchanged.
// [RULE11] Watchdog runs in user mode only when its option bit is set.
// [RULE12] Internal reset is the OR of sources, registered on phase one.
// [RULE13] External reset lasts while the reset input stays low.
// [RULE14] Power-up reset holds internal reset for 4064 cycles.
// [RULE15] Internal reset stays while any source is still active.
// [RULE16] Watchdog is an 18-stage counter whose overflow resets.
// [RULE17] Writing zero to bit 0 of the clear location clears the watchdog.
// [RULE18] Watchdog output blocked while option clear or high voltage on pin.
// [RULE19] Reading the clear location returns the unused vector byte.
// [RULE20] Software should set stop-to-halt or disable watchdog for long waits.
// [RULE21] Wake-up interrupt reaches the core only after the resume delay.
`include "rmlw_regs.vh"
module rmlw_reset_mode_lowpower_watchdog #(
   parameter STAB_CYCLES = `RMLW_STAB_CYCLES,
   parameter WDOG_STAGES = `RMLW_WDOG_STAGES,
   parameter [7:0] UNUSED_VECTOR_BYTE = 8'h00
) (
   input  wire                   clk,
   input  wire                   sys_rst,
   input  wire                   resetPin_n,
   input  wire                   irqPin_n,
   input  wire                   irqHighVolt,
   input  wire                   irqDoubleVolt,
   input  wire                   modeSelectCapturePin,
   input  wire                   stopToHaltSelect,
   input  wire                   wdogOptionEnable,
   input  wire [1:0]             lowPowerInsn,
   input  wire                   timerIrqEnabled,
   input  wire [`RMLW_ADDR_W-1:0] regAddr,
   input  wire [7:0]             regWrData,
   input  wire                   regWrite,
   input  wire                   regRead,
   output reg  [7:0]             regRdData,
   output reg                    internalReset,
   output reg                    bootloaderMode,
   output reg                    oscEnable,
   output reg                    cpuClockEnable,
   output reg                    timerClockEnable,
   output reg                    clearIrqMask,
   output reg                    wakeIrq,
   output reg                    wdogReset
);
   localparam [3:0] ST_RUN  = 4'h1;
   localparam [3:0] ST_STOP = 4'h2;
   localparam [3:0] ST_HALT = 4'h4;
   localparam [3:0] ST_WAIT = 4'h8;
   localparam [`RMLW_STAB_W-1:0] STAB_LAST = STAB_CYCLES - 1;

   // A pin level is taken once the last two stages agree, so a level that
   // flickers across a single sample never reaches the logic behind it.
   function sync_ok;
      input [2:0] s;
      begin
         sync_ok = (s[2] == s[1]);
      end
   endfunction

   // The reset pin counts as released when a settled high level follows
   // the low level that was last accepted.
   function sync_rise;
      input [2:0] s;
      input       level;
      begin
         sync_rise = !level && s[2] && s[1];
      end
   endfunction

   function hits_clear_loc;
      input [`RMLW_ADDR_W-1:0] addr;
      begin
         hits_clear_loc = (addr == `RMLW_WDOG_CLR_ADDR);
      end
   endfunction

   reg [2:0] rstSync;
   reg [2:0] irqSync;
   reg [2:0] vppSync;
   reg [2:0] vdblSync;
   reg [2:0] modeSelSync;
   reg       rstLevel_n;
   reg       irqLevel_n;
   reg       vppLevel;
   reg       vdblLevel;
   reg       modeSelLevel;
   reg       modeLatch;
   reg [3:0] state;
   reg [`RMLW_STAB_W-1:0] stabCount;
   reg       stabRun;
   reg       porActive;
   reg [`RMLW_STAB_W-1:0] porCount;
   reg [WDOG_STAGES-1:0] wdogCount;
   reg       wdogPulse;
   reg       pendWake;
   wire      wdogActive;
   wire      wdogClear;
   wire      wdogTick;
   wire      stabDone;
   wire      extIrq;
   wire      wakeEvent;
   wire      rstRise;

   // The reset pin starts out as held low so that the core is kept in
   // reset until the pin has been seen high through the whole chain.
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rstSync    <= 3'h0;
         rstLevel_n <= 1'b0;
      end else begin
         rstSync <= {rstSync[1:0], resetPin_n};
         if (sync_ok(rstSync))
            rstLevel_n <= rstSync[2]; // RULE13
      end
   end

   // The interrupt chain starts at the idle high level, otherwise a false
   // wake request would follow every reset.
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irqSync    <= 3'h7;
         irqLevel_n <= 1'b1;
      end else begin
         irqSync <= {irqSync[1:0], irqPin_n};
         if (sync_ok(irqSync))
            irqLevel_n <= irqSync[2];
      end
   end

   // Programming voltage only matters at the reset rise and at a watchdog reset, so a slow chain
   // costs nothing here.
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         vppSync  <= 3'h0;
         vppLevel <= 1'b0;
      end else begin
         vppSync <= {vppSync[1:0], irqHighVolt};
         if (sync_ok(vppSync))
            vppLevel <= vppSync[2];
      end
   end

   // Double supply on the interrupt pin only gates the watchdog output,
   // so a few cycles of lag before it takes hold are harmless.
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         vdblSync  <= 3'h0;
         vdblLevel <= 1'b0;
      end else begin
         vdblSync <= {vdblSync[1:0], irqDoubleVolt};
         if (sync_ok(vdblSync))
            vdblLevel <= vdblSync[2];
      end
   end

   // The mode strap must have settled here before the reset pin rises, as
   // both chains are equally long.
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         modeSelSync  <= 3'h0;
         modeSelLevel <= 1'b0;
      end else begin
         modeSelSync <= {modeSelSync[1:0], modeSelectCapturePin};
         if (sync_ok(modeSelSync))
            modeSelLevel <= modeSelSync[2];
      end
   end

   // Halt and wait leave on the same set of events, so they share one
   // decoded wake request.
   assign extIrq    = ~irqLevel_n;
   assign wakeEvent = extIrq | timerIrqEnabled;
   assign rstRise   = sync_rise(rstSync, rstLevel_n);
   assign stabDone  = (stabCount == STAB_LAST);

   // The stabilisation timer runs free outside stop, so a halt exit waits
   // for its next wrap; a stop exit restarts it from zero.
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stabCount <= {`RMLW_STAB_W{1'b0}};
      end else if (state == ST_STOP && !stabRun) begin
         stabCount <= {`RMLW_STAB_W{1'b0}}; // RULE4
      end else if (stabDone) begin
         stabCount <= {`RMLW_STAB_W{1'b0}};
      end else begin
         stabCount <= stabCount + 1'b1;
      end
   end

   // Power-up hold counts from the release of the system reset; the count
   // stops with the hold so it cannot wrap and start a second one.
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         porCount <= {`RMLW_STAB_W{1'b0}};
      else if (porActive)
         porCount <= porCount + 1'b1;
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         porActive <= 1'b1;
      else if (porActive && porCount == STAB_LAST)
         porActive <= 1'b0; // RULE14
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         internalReset <= 1'b1;
      end else begin
         // Every source feeds one OR, so whichever source ends last
         // decides when the core leaves reset.
         internalReset <= porActive | ~rstLevel_n // RULE12 RULE13
                          | wdogPulse; // RULE15
      end
   end

   // The mode strap is caught on the synchronised rise of the reset pin;
   // the latched strap outlives the pin for later watchdog resets.
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         modeLatch <= 1'b0;
      else if (rstRise)
         modeLatch <= modeSelLevel; // RULE3
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bootloaderMode <= 1'b0;
      end else if (rstRise) begin
         bootloaderMode <= vppLevel & modeSelLevel; // RULE1 RULE2
      end else if (wdogPulse) begin
         bootloaderMode <= vppLevel & modeLatch; // RULE3
      end
   end

   // Low-power state machine; it touches no other register of the chip.
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state            <= ST_RUN;
         stabRun          <= 1'b0;
         oscEnable        <= 1'b1;
         cpuClockEnable   <= 1'b1;
         timerClockEnable <= 1'b1;
         clearIrqMask     <= 1'b0;
         pendWake         <= 1'b0;
         wakeIrq          <= 1'b0;
      end else begin
         clearIrqMask <= 1'b0;
         wakeIrq      <= 1'b0;
         if (internalReset) begin
            state            <= ST_RUN;
            stabRun          <= 1'b0;
            oscEnable        <= 1'b1;
            cpuClockEnable   <= 1'b1;
            timerClockEnable <= 1'b1;
            pendWake         <= 1'b0;
         end else begin
            case (state)
               ST_RUN: begin
                  if (lowPowerInsn == `RMLW_INSN_STOP) begin
                     clearIrqMask   <= 1'b1; // RULE5
                     cpuClockEnable <= 1'b0; // RULE10
                     if (stopToHaltSelect) begin
                        state <= ST_HALT; // RULE7
                     end else begin
                        state            <= ST_STOP;
                        oscEnable        <= 1'b0; // RULE4
                        timerClockEnable <= 1'b0;
                     end
                  end else if (lowPowerInsn == `RMLW_INSN_WAIT) begin
                     clearIrqMask   <= 1'b1; // RULE5
                     cpuClockEnable <= 1'b0; // RULE9
                     state          <= ST_WAIT;
                  end
               end
               ST_STOP: begin
                  if (extIrq && !stabRun) begin
                     stabRun   <= 1'b1; // RULE6
                     oscEnable <= 1'b1;
                     pendWake  <= 1'b1;
                  end else if (stabRun && stabDone) begin
                     stabRun          <= 1'b0;
                     state            <= ST_RUN;
                     cpuClockEnable   <= 1'b1;
                     timerClockEnable <= 1'b1;
                     wakeIrq          <= pendWake; // RULE21
                     pendWake         <= 1'b0;
                  end
               end
               ST_HALT: begin
                  if (wakeEvent)
                     pendWake <= 1'b1; // RULE8
                  if ((pendWake || wakeEvent) && stabDone) begin
                     state          <= ST_RUN;
                     cpuClockEnable <= 1'b1;
                     wakeIrq        <= 1'b1; // RULE21
                     pendWake       <= 1'b0;
                  end
               end
               ST_WAIT: begin
                  if (wakeEvent) begin
                     state          <= ST_RUN; // RULE9
                     cpuClockEnable <= 1'b1;
                     wakeIrq        <= 1'b1;
                  end
               end
               default: begin
                  state <= ST_RUN;
               end
            endcase
         end
      end
   end

   // Bootloader work must not be cut short by a watchdog that user code
   // never gets to service, so the counter is held there as well.
   assign wdogActive = wdogOptionEnable & ~vdblLevel
                       & ~bootloaderMode; // RULE11 RULE18
   assign wdogClear  = regWrite && hits_clear_loc(regAddr)
                       && !regWrData[`RMLW_WDOG_CLR_BIT]; // RULE17
   // The counter freezes in stop because the oscillator is off there.
   assign wdogTick   = !(internalReset || wdogClear || !wdogActive)
                       && state != ST_STOP; // RULE4

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wdogCount <= {WDOG_STAGES{1'b0}};
      end else if (internalReset || wdogClear || !wdogActive) begin
         wdogCount <= {WDOG_STAGES{1'b0}};
      end else if (wdogTick) begin
         wdogCount <= wdogCount + 1'b1; // RULE16
      end
   end

   // Overflow is the carry out of the last stage.
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         wdogPulse <= 1'b0;
      else
         wdogPulse <= wdogTick & (&wdogCount); // RULE16
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         wdogReset <= 1'b0;
      else
         wdogReset <= wdogTick & (&wdogCount);
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         regRdData <= `RMLW_RD_IDLE;
      end else if (regRead && hits_clear_loc(regAddr)) begin
         regRdData <= UNUSED_VECTOR_BYTE; // RULE19
      end else begin
         regRdData <= `RMLW_RD_IDLE;
      end
   end
endmodule

// ===== rmlw_regs.vh
// Constants for the reset, mode, low-power and watchdog control block.
// Assumes a 20 MHz internal clock and an 8-bit register port.
`ifndef RMLW_REGS_VH
`define RMLW_REGS_VH
`define RMLW_ADDR_W          13
`define RMLW_WDOG_CLR_ADDR   13'h1ff0
`define RMLW_WDOG_CLR_BIT    0
`define RMLW_RD_IDLE         8'h00
`define RMLW_STAB_CYCLES     12'hfe0
`define RMLW_STAB_W          12
`define RMLW_WDOG_STAGES     18
`define RMLW_INSN_NONE       2'h0
`define RMLW_INSN_STOP       2'h1
`define RMLW_INSN_WAIT       2'h2
`endif

// ===== rmlw_checker_assertions.sv
// Port-level checker for the reset, mode, low-power and watchdog block.
// Assumes a single clock domain with sys_rst as its asynchronous reset.
module rmlw_chk #(
   parameter       STAB_CYCLES        = 16,
   parameter [7:0] UNUSED_VECTOR_BYTE = 8'h00
) (
   input wire        clk,
   input wire        sys_rst,
   input wire        resetPin_n,
   input wire        stopToHaltSelect,
   input wire        wdogOptionEnable,
   input wire [1:0]  lowPowerInsn,
   input wire [12:0] regAddr,
   input wire        regRead,
   input wire [7:0]  regRdData,
   input wire        internalReset,
   input wire        oscEnable,
   input wire        cpuClockEnable,
   input wire        timerClockEnable,
   input wire        clearIrqMask,
   input wire        wakeIrq,
   input wire        wdogReset
);
   reg [12:0] upCnt;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         upCnt <= 13'h0;
      else if (upCnt < STAB_CYCLES)
         upCnt <= upCnt + 13'h1;
   end
   sequence sleepReq;
      (lowPowerInsn == 2'h1 || lowPowerInsn == 2'h2) && cpuClockEnable &&
      !internalReset;
   endsequence
   sequence extLow;
      (!resetPin_n)[*5];
   endsequence
   AST_POR: assert property (upCnt < STAB_CYCLES - 1 |-> internalReset)
      else $error("internal reset dropped during power-up hold");
   AST_EXT_RST: assert property (extLow |=> internalReset)
      else $error("internal reset low while reset pin held low");
   AST_WDOG: assert property (wdogReset |=> internalReset)
      else $error("watchdog overflow did not raise internal reset");
   AST_WDOG_OFF: assert property ((!wdogOptionEnable)[*3] |-> !wdogReset)
      else $error("watchdog fired with its option clear");
   AST_SLEEP: assert property (sleepReq |=> clearIrqMask && !cpuClockEnable)
      else $error("low-power entry missing mask clear or core stop");
   AST_STOP: assert property (sleepReq ##0 (lowPowerInsn == 2'h1 &&
      !stopToHaltSelect) |=> !oscEnable && !timerClockEnable)
      else $error("stop left oscillator or timers running");
   AST_HALT: assert property (sleepReq ##0 (lowPowerInsn == 2'h1 &&
      stopToHaltSelect) |=> oscEnable && timerClockEnable)
      else $error("halt stopped oscillator or timers");
   AST_RESUME: assert property ($rose(oscEnable) && !internalReset
      |-> (!cpuClockEnable)[*8])
      else $error("core clock resumed before stabilization");
   AST_WAKE: assert property (wakeIrq |-> cpuClockEnable &&
      !$past(cpuClockEnable))
      else $error("wake interrupt not aligned with clock resume");
   AST_READ: assert property (regRead |=> regRdData == (($past(regAddr)
      == 13'h1ff0) ? UNUSED_VECTOR_BYTE : 8'h00))
      else $error("wrong read data");
   AST_RD_IDLE: assert property (!regRead |=> regRdData == 8'h00)
      else $error("read data did not return to zero");
endmodule
bind rmlw_reset_mode_lowpower_watchdog rmlw_chk #(
   .STAB_CYCLES(STAB_CYCLES), .UNUSED_VECTOR_BYTE(UNUSED_VECTOR_BYTE)
) chk_u (.clk(clk), .sys_rst(sys_rst), .resetPin_n(resetPin_n),
   .stopToHaltSelect(stopToHaltSelect), .wdogOptionEnable(wdogOptionEnable),
   .lowPowerInsn(lowPowerInsn), .regAddr(regAddr), .regRead(regRead),
   .regRdData(regRdData), .internalReset(internalReset),
   .oscEnable(oscEnable), .cpuClockEnable(cpuClockEnable),
   .timerClockEnable(timerClockEnable), .clearIrqMask(clearIrqMask),
   .wakeIrq(wakeIrq), .wdogReset(wdogReset));

// ===== rmlw_irq_model.sv
// Model of the interrupt line as the core side sees it.
// A request holds the pin low until the block presents the wake interrupt.
module rmlw_irq_model (
   input  wire clk,
   input  wire irqReq,
   input  wire wakeIrq,
   output reg  irqPin_n
);
   timeunit 1ns;
   timeprecision 1ns;
   initial irqPin_n = 1'b1;
   always @(posedge clk) begin
      if (wakeIrq)
         irqPin_n <= 1'b1;
      else if (irqReq)
         irqPin_n <= 1'b0;
   end
endmodule

// ===== tb.sv
// Self-checking bench for the reset, mode, low-power and watchdog block.
// Counts are shortened by parameter; the interrupt pin comes from the model.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 0, sys_rst = 1, resetPin_n = 1, irqHighVolt = 0;
   logic        irqDoubleVolt = 0, modeSelectCapturePin = 0, irqReq = 0;
   logic        stopToHaltSelect = 0, wdogOptionEnable = 0, irqPin_n;
   logic        timerIrqEnabled = 0, regWrite = 0, regRead = 0;
   logic [1:0]  lowPowerInsn = 0;
   logic [12:0] regAddr = 0;
   logic [7:0]  regWrData = 0, regRdData;
   logic        internalReset, bootloaderMode, oscEnable, cpuClockEnable;
   logic        timerClockEnable, clearIrqMask, wakeIrq, wdogReset;
   int          fails = 0, cmp_count = 0, wdogSeen = 0, n;
   rmlw_reset_mode_lowpower_watchdog #(.STAB_CYCLES(16), .WDOG_STAGES(6),
      .UNUSED_VECTOR_BYTE(8'h5a)) dut_u (.*);
   rmlw_irq_model irq_u (.clk(clk), .irqReq(irqReq), .wakeIrq(wakeIrq),
      .irqPin_n(irqPin_n));
   always #25 clk = ~clk;
   always @(posedge clk) if (wdogReset === 1'b1) wdogSeen++;
   task finish_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // A wait that exhausts its bound ends the run as a mismatch.
   task waitFor(input int sel, input int lim, output int k);
      k = 0;
      while (!((sel == 0 && wakeIrq === 1'b1) || (sel == 1 && wdogReset
         === 1'b1) || (sel == 2 && internalReset === 1'b0))) begin
         if (k >= lim) begin
            chk(8'h0, 8'(sel + 1));
            finish_test;
         end
         @(posedge clk);
         #1 k++;
      end
   endtask
   task wr(input logic [12:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   task rd(input logic [12:0] a, input logic [7:0] e);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 chk(regRdData, e);
   endtask
   task pinReset(input logic hv, input logic ms);
      @(posedge clk);
      resetPin_n <= 1'b0;
      irqHighVolt <= hv;
      modeSelectCapturePin <= ms;
      repeat (8) @(posedge clk);
      resetPin_n <= 1'b1;
      repeat (6) @(posedge clk);
      waitFor(2, 40, n);
   endtask
   task sleep(input logic [1:0] insn, input logic sth);
      @(posedge clk);
      lowPowerInsn <= insn;
      stopToHaltSelect <= sth;
      @(posedge clk);
      lowPowerInsn <= 2'h0;
      #1 chk(clearIrqMask, 1);
   endtask
   task irqPulse;
      @(posedge clk);
      irqReq <= 1'b1;
      @(posedge clk);
      irqReq <= 1'b0;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      #1 waitFor(2, 60, n);
      chk(8'(n >= 16), 1);
      rd(13'h1ff0, 8'h5a);
      wr(13'h1ff1, 8'h00);
      rd(13'h1ff1, 8'h00);
      pinReset(1, 1);
      chk(bootloaderMode, 1);
      pinReset(1, 0);
      chk(bootloaderMode, 0);
      pinReset(0, 1);
      chk(bootloaderMode, 0);
      repeat (100) @(posedge clk);
      chk(8'(wdogSeen), 0);
      wdogOptionEnable <= 1'b1;
      repeat (4) begin
         repeat (40) @(posedge clk);
         wr(13'h1ff0, 8'h00);
      end
      chk(8'(wdogSeen), 0);
      modeSelectCapturePin <= 1'b0;
      irqHighVolt <= 1'b1;
      wr(13'h1ff0, 8'h00);
      wr(13'h1ff0, 8'h01);
      #1 waitFor(1, 100, n);
      chk(8'(n >= 56 && n <= 70), 1);
      repeat (4) @(posedge clk);
      #1 chk(bootloaderMode, 1);
      pinReset(0, 0);
      irqDoubleVolt <= 1'b1;
      repeat (100) @(posedge clk);
      chk(8'(wdogSeen), 1);
      irqDoubleVolt <= 1'b0;
      waitFor(1, 100, n);
      wdogOptionEnable <= 1'b0;
      repeat (8) @(posedge clk);
      sleep(2, 0);
      chk(cpuClockEnable, 0);
      irqPulse;
      waitFor(0, 40, n);
      repeat (8) @(posedge clk);
      sleep(1, 0);
      chk(oscEnable, 0);
      timerIrqEnabled <= 1'b1;
      repeat (30) @(posedge clk);
      #1 chk(cpuClockEnable, 0);
      irqPulse;
      waitFor(0, 60, n);
      chk(8'(n >= 16), 1);
      repeat (8) @(posedge clk);
      sleep(1, 1);
      chk(timerClockEnable, 1);
      waitFor(0, 25, n);
      chk(8'(n <= 17), 1);
      timerIrqEnabled <= 1'b0;
      sleep(1, 0);
      pinReset(0, 0);
      chk(cpuClockEnable, 1);
      finish_test;
   end
endmodule
